// ---- steer_pkg.sv ----
package steer_pkg;
    localparam logic [11:0] ADDR_STEER     = 12'h000;
    localparam logic [11:0] ADDR_UNIT_CTRL = 12'h004;
    localparam logic [11:0] ADDR_SHUTDOWN  = 12'h008;
    localparam logic [11:0] ADDR_STATUS    = 12'h00C;
    localparam logic [11:0] ADDR_PORT      = 12'h010;
    localparam logic [11:0] ADDR_PERIOD    = 12'h014;
    localparam logic [11:0] ADDR_DUTY      = 12'h018;
    localparam int STEER_SYNC_BIT = 4;
    localparam int NUM_PINS       = 4;
    localparam logic [4:0] STEER_RESET  = 5'h01;
    localparam logic [1:0] MODE_PWM_HI  = 2'h3;
    localparam logic [1:0] CFG_SINGLE   = 2'h0;
    localparam logic [7:0] UNIT_RESET   = 8'h00;
    localparam logic [7:0] PERIOD_RESET = 8'hFF;
    localparam logic [7:0] DUTY_RESET   = 8'h00;
    localparam logic [3:0] SHUT_RESET   = 4'h0;
    localparam int         SHUT_AC_LSB  = 2;
    localparam int         SHUT_BD_LSB  = 0;
    localparam logic [3:0] PORT_RESET   = 4'h0;
endpackage

// ---- steer_period_timer.sv ----
`timescale 1ns/1ps
module steer_period_timer
    import steer_pkg::*;
#(
    parameter int WIDTH = 8
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic             run,
    input  wire logic [WIDTH-1:0] period,
    input  wire logic [WIDTH-1:0] duty,
    output logic                  period_start,
    output logic                  pwm_raw
);
    logic [WIDTH-1:0] count_q;
    logic [WIDTH-1:0] count_d;

    always_comb begin
        count_d = count_q;
        if (run) begin
            if (count_q >= period) begin
                count_d = '0;
            end else begin
                count_d = count_q + 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_q <= '0;
        end else begin
            count_q <= count_d;
        end
    end

    // one-cycle pulse on wrap; stalls with run low
    assign period_start = run && (count_q >= period);
    assign pwm_raw      = count_q < duty;
endmodule

// ---- pwm_pulse_steering.sv ----
`timescale 1ns/1ps
// Operation
// - steering acts only when mode high bits are 11 and output config is 00
// - set enable routes pwm to pin with mode low-bit polarity; clear gives port
// - sync bit zero: new steering applies right after the register write
// - sync bit one: new steering applies at next pwm period start
// - sleep freezes timer and pin outputs; registers still take writes; resume on wake
// - idle and other power states keep running on the supplied clock
// - on clock failure keep running and set oscillator fail flag
// - reset makes pins inputs and registers return to reset values
// - steering register top three bits read zero; reset value enables pin a only
// - shutdown forces only steered pins into their shutdown states
module pwm_pulse_steering
    import steer_pkg::*;
#(
    parameter int TW = 8
) (
    input  wire logic                pclk,
    input  wire logic                presetn,
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [11:0]         paddr,
    input  wire logic [31:0]         pwdata,
    input  wire logic [3:0]          pstrb,
    output logic      [31:0]         prdata,
    output logic                     pready,
    output logic                     pslverr,
    input  wire logic                sleep_req,
    input  wire logic                clock_fail,
    input  wire logic                shutdown_in,
    input  wire logic [NUM_PINS-1:0] pin_dir_in,
    output logic      [NUM_PINS-1:0] pin_out,
    output logic      [NUM_PINS-1:0] pin_oe_n
);
    logic [4:0]          steer_q, steer_d;
    logic [3:0]          active_q, active_d;
    logic [7:0]          unit_q, unit_d;
    logic [3:0]          shut_q, shut_d;
    logic [3:0]          port_q, port_d;
    logic [TW-1:0]       period_q, period_d;
    logic [TW-1:0]       duty_q, duty_d;
    logic                osc_fail_q, osc_fail_d;
    logic                pend_q, pend_d;
    logic [NUM_PINS-1:0] pin_out_q, pin_out_d;
    logic [NUM_PINS-1:0] oe_n_q, oe_n_d;
    logic [2:0]          sl_sync_q, cf_sync_q, sd_sync_q;
    logic [NUM_PINS-1:0] dir_s1_q, dir_s2_q;
    logic                sleeping, cfail, shut_act;
    logic [NUM_PINS-1:0] shut_tri, shut_lvl;
    logic                wr, rd, hit, steer_mode, period_start, pwm_raw, pwm_pol, run;

    // pin-side inputs cross through two flops before use
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sl_sync_q <= '0;
            cf_sync_q <= '0;
            sd_sync_q <= '0;
            dir_s1_q  <= '1;
            dir_s2_q  <= '1;
        end else begin
            sl_sync_q <= {sl_sync_q[1:0], sleep_req};
            cf_sync_q <= {cf_sync_q[1:0], clock_fail};
            sd_sync_q <= {sd_sync_q[1:0], shutdown_in};
            dir_s1_q  <= pin_dir_in;
            dir_s2_q  <= dir_s1_q;
        end
    end
    assign sleeping = sl_sync_q[1];
    assign cfail    = cf_sync_q[2] == 1'b0 && cf_sync_q[1];
    assign shut_act = sd_sync_q[1];

    // single-output pwm only
    assign steer_mode = unit_q[3:2] == MODE_PWM_HI && unit_q[7:6] == CFG_SINGLE;
    // timer runs on whatever clock is supplied; stops only in sleep
    assign run = !sleeping;

    steer_period_timer #(
        .WIDTH(TW)
    ) u_timer (
        .pclk        (pclk),
        .presetn     (presetn),
        .run         (run),
        .period      (period_q),
        .duty        (duty_q),
        .period_start(period_start),
        .pwm_raw     (pwm_raw)
    );

    assign wr      = psel && penable && pwrite;
    assign rd      = psel && !pwrite;
    assign pready  = 1'b1;
    assign hit     = paddr == ADDR_STEER || paddr == ADDR_UNIT_CTRL || paddr == ADDR_SHUTDOWN
                  || paddr == ADDR_STATUS || paddr == ADDR_PORT || paddr == ADDR_PERIOD
                  || paddr == ADDR_DUTY;
    assign pslverr = psel && penable && !hit;
    assign pwm_pol = pwm_raw ^ unit_q[0];

    always_comb begin
        steer_d    = steer_q;
        unit_d     = unit_q;
        shut_d     = shut_q;
        port_d     = port_q;
        period_d   = period_q;
        duty_d     = duty_q;
        osc_fail_d = osc_fail_q | cfail;
        active_d   = active_q;
        pend_d     = pend_q;
        if (wr && pstrb[0]) begin
            case (paddr)
                ADDR_STEER: begin
                    steer_d = pwdata[4:0];
                    pend_d  = 1'b1;
                end
                ADDR_UNIT_CTRL: unit_d   = pwdata[7:0];
                ADDR_SHUTDOWN:  shut_d   = pwdata[3:0];
                ADDR_PORT:      port_d   = pwdata[3:0];
                ADDR_PERIOD:    period_d = pwdata[TW-1:0];
                ADDR_DUTY:      duty_d   = pwdata[TW-1:0];
                // set wins over a write-one clear
                ADDR_STATUS:    osc_fail_d = cfail | (osc_fail_q & ~pwdata[0]);
                default: ;
            endcase
        end
        // apply pending steering either now or at period wrap
        if (pend_q) begin
            if (!steer_q[STEER_SYNC_BIT]) begin
                active_d = steer_q[3:0];
                pend_d   = wr && pstrb[0] && paddr == ADDR_STEER;
            end else if (period_start) begin
                active_d = steer_q[3:0];
                pend_d   = wr && pstrb[0] && paddr == ADDR_STEER;
            end
        end
    end

    // pins a/c share one shutdown field, b/d the other
    for (genvar g = 0; g < NUM_PINS; g++) begin : g_shut_map
        localparam int LSB = (g % 2 == 0) ? SHUT_AC_LSB : SHUT_BD_LSB;
        assign shut_tri[g] = shut_q[LSB + 1];
        assign shut_lvl[g] = shut_q[LSB];
    end

    // frozen in sleep: pins keep their last value
    always_comb begin
        pin_out_d = pin_out_q;
        oe_n_d    = oe_n_q;
        if (!sleeping) begin
            for (int i = 0; i < NUM_PINS; i++) begin
                oe_n_d[i]    = dir_s2_q[i];
                pin_out_d[i] = port_q[i];
                if (steer_mode && active_q[i]) begin
                    pin_out_d[i] = pwm_pol;
                    if (shut_act) begin
                        if (shut_tri[i]) begin
                            oe_n_d[i] = 1'b1;
                        end else begin
                            pin_out_d[i] = shut_lvl[i];
                        end
                    end
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            steer_q    <= STEER_RESET;
            active_q   <= STEER_RESET[3:0];
            unit_q     <= UNIT_RESET;
            shut_q     <= SHUT_RESET;
            port_q     <= PORT_RESET;
            period_q   <= PERIOD_RESET[TW-1:0];
            duty_q     <= DUTY_RESET[TW-1:0];
            osc_fail_q <= 1'b0;
            pend_q     <= 1'b0;
            pin_out_q  <= '0;
            oe_n_q     <= '1;
        end else begin
            steer_q    <= steer_d;
            active_q   <= active_d;
            unit_q     <= unit_d;
            shut_q     <= shut_d;
            port_q     <= port_d;
            period_q   <= period_d;
            duty_q     <= duty_d;
            osc_fail_q <= osc_fail_d;
            pend_q     <= pend_d;
            pin_out_q  <= pin_out_d;
            oe_n_q     <= oe_n_d;
        end
    end

    assign pin_out  = pin_out_q;
    assign pin_oe_n = oe_n_q;

    always_comb begin
        prdata = '0;
        if (rd) begin
            case (paddr)
                ADDR_STEER:     prdata = {27'h0000000, steer_q};
                ADDR_UNIT_CTRL: prdata = {24'h000000, unit_q};
                ADDR_SHUTDOWN:  prdata = {28'h0000000, shut_q};
                ADDR_STATUS:    prdata = {25'h0, sleeping, shut_act, active_q, osc_fail_q};
                ADDR_PORT:      prdata = {28'h0000000, port_q};
                ADDR_PERIOD:    prdata = {{(32-TW){1'b0}}, period_q};
                ADDR_DUTY:      prdata = {{(32-TW){1'b0}}, duty_q};
                default:        prdata = '0;
            endcase
        end
    end

    property p_async_apply;
        @(posedge pclk) disable iff (!presetn)
        (pend_q && !steer_q[STEER_SYNC_BIT]) |=> (active_q == $past(steer_q[3:0]));
    endproperty
    AST_ASYNC_APPLY: assert property (p_async_apply) else $error("steering not applied");

    property p_sync_hold;
        @(posedge pclk) disable iff (!presetn)
        (steer_q[STEER_SYNC_BIT] && !period_start) |=> $stable(active_q);
    endproperty
    AST_SYNC_HOLD: assert property (p_sync_hold) else $error("steering changed mid period");

    for (genvar g = 0; g < NUM_PINS; g++) begin : g_pin_chk
        localparam int LSB = (g % 2 == 0) ? SHUT_AC_LSB : SHUT_BD_LSB;

        property p_port_pin;
            @(posedge pclk) disable iff (!presetn)
            (!sleeping && !active_q[g]) |=> (pin_out_q[g] == $past(port_q[g]));
        endproperty
        AST_PORT_PIN: assert property (p_port_pin) else $error("unsteered pin not port");

        property p_pin_pwm;
            @(posedge pclk) disable iff (!presetn)
            (!sleeping && steer_mode && active_q[g] && !shut_act) |=> (pin_out_q[g] == $past(pwm_pol));
        endproperty
        AST_PIN_PWM: assert property (p_pin_pwm) else $error("steered pin not pwm");

        property p_shut_pin;
            @(posedge pclk) disable iff (!presetn)
            (!sleeping && steer_mode && active_q[g] && shut_act)
                |=> ($past(shut_q[LSB + 1]) ? oe_n_q[g] : (pin_out_q[g] == $past(shut_q[LSB])));
        endproperty
        AST_SHUT_PIN: assert property (p_shut_pin) else $error("shutdown state wrong");

        property p_dir_oe;
            @(posedge pclk) disable iff (!presetn)
            (!sleeping && !(steer_mode && active_q[g] && shut_act && shut_tri[g]))
                |=> (oe_n_q[g] == $past(dir_s2_q[g]));
        endproperty
        AST_DIR_OE: assert property (p_dir_oe) else $error("pin driver not from direction");
    end

    property p_sleep_hold;
        @(posedge pclk) disable iff (!presetn)
        sleeping |=> ($stable(pin_out_q) && $stable(oe_n_q));
    endproperty
    AST_SLEEP_HOLD: assert property (p_sleep_hold) else $error("pins moved in sleep");

    property p_osc_flag;
        @(posedge pclk) disable iff (!presetn)
        cfail |=> osc_fail_q;
    endproperty
    AST_OSC_FLAG: assert property (p_osc_flag) else $error("osc fail flag not set");

    property p_mode_gate;
        @(posedge pclk) disable iff (!presetn)
        (!sleeping && !steer_mode) |=> (pin_out_q == $past(port_q));
    endproperty
    AST_MODE_GATE: assert property (p_mode_gate) else $error("pwm outside steering mode");

    property p_steer_zero;
        @(posedge pclk) disable iff (!presetn)
        (rd && paddr == ADDR_STEER) |-> (prdata[31:STEER_SYNC_BIT+1] == '0);
    endproperty
    AST_STEER_ZERO: assert property (p_steer_zero) else $error("steering top bits not zero");

    // a synchronised update waits for the timer wrap
    sequence s_sync_pending;
        pend_q && steer_q[STEER_SYNC_BIT];
    endsequence

    sequence s_period_wrap;
        period_start;
    endsequence

    property p_sync_apply;
        @(posedge pclk) disable iff (!presetn)
        (s_sync_pending ##0 s_period_wrap) |=> (active_q == $past(steer_q[3:0]));
    endproperty
    AST_SYNC_APPLY: assert property (p_sync_apply) else $error("steering missed period start");

    property p_active_src;
        @(posedge pclk) disable iff (!presetn)
        !pend_q |=> $stable(active_q);
    endproperty
    AST_ACTIVE_SRC: assert property (p_active_src) else $error("active copy moved unasked");

    property p_osc_hold;
        @(posedge pclk) disable iff (!presetn)
        (osc_fail_q && !(wr && pstrb[0] && paddr == ADDR_STATUS && pwdata[0]))
            |=> osc_fail_q;
    endproperty
    AST_OSC_HOLD: assert property (p_osc_hold) else $error("osc fail flag lost");
endmodule

// ---- pin_load.sv ----
`timescale 1ns/1ps
module pin_load (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic [3:0] pin_out,
    input  wire logic [3:0] pin_oe_n,
    output logic      [3:0] pin_level
);
    logic [3:0] last_q;
    logic [3:0] last_d;
    // a released pin shows the inverse of its last driven level, so stale values never match
    always_comb begin
        last_d = last_q;
        for (int i = 0; i < 4; i++) begin
            pin_level[i] = pin_oe_n[i] ? ~last_q[i] : pin_out[i];
            if (!pin_oe_n[i]) begin
                last_d[i] = pin_out[i];
            end
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            last_q <= 4'h0;
        end else begin
            last_q <= last_d;
        end
    end
endmodule

// ---- test_pwm_pulse_steering.sv ----
`timescale 1ns/1ps
module test_pwm_pulse_steering;
    import steer_pkg::*;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic        sleep_req = 0, clock_fail = 0, shutdown_in = 0, pready, pslverr, err;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [3:0]  pstrb = 4'hF, pin_dir_in = 4'hF, pin_out, pin_oe_n, pin_level;
    logic [7:0]  snap;
    int          bad_count = 0, comparisons = 0, hi;
    always #20 pclk = ~pclk;
    pwm_pulse_steering #(.TW(8)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .sleep_req(sleep_req),
        .clock_fail(clock_fail), .shutdown_in(shutdown_in), .pin_dir_in(pin_dir_in),
        .pin_out(pin_out), .pin_oe_n(pin_oe_n));
    pin_load load (.pclk(pclk), .presetn(presetn), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
        .pin_level(pin_level));
    task check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task finish_test();
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1; pwrite <= w; paddr <= a; pwdata <= d; penable <= 0;
        @(posedge pclk);
        penable <= 1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata; err = pslverr;
        psel <= 0; penable <= 0;
    endtask
    task count_hi(input int idx);
        hi = 0;
        repeat (8) begin
            @(negedge pclk);
            if (pin_level[idx] === 1'b1) hi++;
        end
    endtask
    task t_regs();
        apb(0, ADDR_STEER, 0); check(rd, 32'h01);
        apb(1, ADDR_STEER, 32'hFF); apb(0, ADDR_STEER, 0); check(rd, 32'h1F);
        apb(0, 12'h020, 0); check(err, 1); check(rd, 0);
        $display("registers done");
    endtask
    task t_pwm();
        apb(1, ADDR_UNIT_CTRL, 32'h0C); apb(1, ADDR_PERIOD, 7); apb(1, ADDR_DUTY, 3);
        apb(1, ADDR_PORT, 32'hA); apb(1, ADDR_STEER, 32'h01);
        @(posedge pclk) pin_dir_in <= 4'h0;
        repeat (4) @(posedge pclk);
        count_hi(0); check(hi, 3); check(pin_level[3:1], 3'b101);
        apb(1, ADDR_UNIT_CTRL, 32'h0D); repeat (3) @(posedge pclk);
        count_hi(0); check(hi, 5); check(pin_level[3:1], 3'b101);
        apb(1, ADDR_UNIT_CTRL, 32'h08); repeat (3) @(posedge pclk);
        count_hi(0); check(hi, 0);
        apb(1, ADDR_UNIT_CTRL, 32'h4C); repeat (3) @(posedge pclk);
        count_hi(0); check(hi, 0);
        $display("pwm routing done");
    endtask
    task t_sync();
        int n;
        apb(1, ADDR_UNIT_CTRL, 32'h0C); apb(1, ADDR_PERIOD, 32'hFF);
        apb(1, ADDR_STEER, 32'h12); apb(0, ADDR_STATUS, 0); check(rd[4:1], 4'h1);
        n = 0;
        do begin
            apb(0, ADDR_STATUS, 0);
            n++;
        end while (rd[4:1] !== 4'h2 && n < 100);
        check(rd[4:1], 4'h2);
        apb(1, ADDR_STEER, 32'h04); apb(0, ADDR_STATUS, 0); check(rd[4:1], 4'h4);
        apb(1, ADDR_PERIOD, 7);
        $display("sync done");
    endtask
    task t_shut();
        apb(1, ADDR_SHUTDOWN, 32'h09); apb(1, ADDR_PORT, 0); apb(1, ADDR_STEER, 32'h03);
        @(posedge pclk) shutdown_in <= 1;
        repeat (4) @(posedge pclk);
        check(pin_oe_n, 4'h1); check(pin_out[3:1], 3'b001);
        apb(0, ADDR_STATUS, 0); check(rd[5], 1);
        @(posedge pclk) shutdown_in <= 0;
        $display("shutdown done");
    endtask
    task t_power();
        @(posedge pclk) sleep_req <= 1;
        repeat (4) @(posedge pclk);
        snap = {pin_oe_n, pin_out};
        repeat (20) @(negedge pclk) check({pin_oe_n, pin_out}, snap);
        apb(0, ADDR_STATUS, 0); check(rd[6], 1);
        @(posedge pclk) sleep_req <= 0;
        repeat (4) @(posedge pclk);
        count_hi(0); check(hi, 3);
        @(posedge pclk) clock_fail <= 1;
        repeat (4) @(posedge pclk);
        apb(0, ADDR_STATUS, 0); check(rd[0], 1);
        count_hi(0); check(hi, 3);
        apb(1, ADDR_STATUS, 32'h01); apb(0, ADDR_STATUS, 0); check(rd[0], 0);
        @(posedge pclk) clock_fail <= 0;
        $display("power states done");
    endtask
    task t_reset();
        @(posedge pclk) presetn <= 0;
        @(negedge pclk) check(pin_oe_n, 4'hF);
        @(posedge pclk) presetn <= 1;
        apb(0, ADDR_STEER, 0); check(rd, 32'h01);
        $display("second reset done");
    endtask
    initial begin
        repeat (3) @(posedge pclk);
        check(pin_oe_n, 4'hF);
        presetn <= 1;
        t_regs();
        t_pwm();
        t_sync();
        t_shut();
        t_power();
        t_reset();
        finish_test();
    end
    initial begin
        #2000000;
        bad_count++;
        finish_test();
    end
endmodule
